// ===== ifd_decoder.sv
// Instruction fetch, format decode and cycle sequencing for the 8-bit core
// Operation
// RULE1: 75 base plus eight optional extended instructions
// RULE2: One 16-bit word; four instructions use two
// RULE3: Single word splits into opcode and operands
// RULE4: Classify as byte, bit, literal or control
// RULE5: Byte ops carry file, destination, access bits
// RULE6: Destination zero accumulator, one file register
// RULE7: Bit ops carry file, bit position, access
// RULE8: Literal ops: constant, pointer target, or none
// RULE9: Control ops: address, shadow mode, table mode
// RULE10: Double word holds 32 bits, top nibble ones
// RULE11: Lone second word executes as no-operation
// RULE12: One cycle; two when taken or jumping
// RULE13: Double-word instructions take two cycles
// RULE14: Instruction cycle is four oscillator periods
// RULE15: Taken skip over double word: three cycles
// RULE16: Access bit zero ignores bank selector
// RULE17: Table mode: keep, post-inc, post-dec, pre-inc
// RULE18: Shadow mode bit saves/restores shadow registers
// RULE19: Second word fetched, lower bits complete operand
module ifd_decoder
    import ifd_pkg::*;
(
    input  wire logic                core_clk_in,
    input  wire logic                rst_in,
    input  wire logic [RA_W-1:0]     reg_addr_in,
    input  wire logic [DW-1:0]       reg_wdata_in,
    input  wire logic                reg_wr_in,
    input  wire logic                reg_rd_in,
    output logic [DW-1:0]            reg_rdata_out,
    output logic [PC_W-1:0]          pm_addr_out,
    input  wire logic [IW-1:0]       pm_data_in,
    input  wire logic                cond_true_in,
    input  wire logic [PC_W-1:0]     ret_addr_in,
    output logic [PH_W-1:0]          phase_out,
    output logic                     cycle_end_out,
    output logic                     exec_valid_out,
    output ifd_pkg::ifd_group_t      group_out,
    output logic [OP_W-1:0]          opcode_out,
    output logic [FA_W-1:0]          file_addr_out,
    output logic [FA_W-1:0]          file_dst_out,
    output logic                     wr_accum_out,
    output logic                     wr_file_out,
    output logic                     access_bank_out,
    output logic                     use_bank_selector_out,
    output logic [BP_W-1:0]          bit_pos_out,
    output logic [PC_W-1:0]          literal_out,
    output logic [PS_W-1:0]          ptr_sel_out,
    output logic                     shadow_save_out,
    output logic                     shadow_restore_out,
    output logic                     tbl_rd_out,
    output logic                     tbl_wr_out,
    output ifd_pkg::ifd_tbl_t        tbl_mode_out,
    output logic                     call_out,
    output logic                     ret_out,
    output logic [PC_W-1:0]          ret_pc_out,
    output logic                     ext_op_out,
    output logic [XI_W-1:0]          ext_idx_out,
    output logic                     dword_out,
    output logic                     test_out
);
    import ifd_pkg::*;

    logic [PC_W-1:0] pc;
    logic [IW-1:0]   ir;
    ifd_state_t      state;
    ifd_dec_t        dec_q;
    logic            valid;
    logic [PC_W-1:0] ret_pc;
    logic [1:0]      ctrl;
    logic            blocked;
    logic            tick;

    logic [PC_W-1:0] next_pc;
    logic [IW-1:0]   next_ir;
    ifd_state_t      next_state;
    ifd_dec_t        next_dec;
    logic            next_valid;
    ifd_dec_t        fresh;
    ifd_dec_t        joined;

    ifd_phase #(
        .N           (PHASES)
    ) u_phase (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .phase_out   (phase_out),
        .tick_out    (tick)
    ); // RULE14

    // Splits a word pair into class and operand fields
    function automatic ifd_dec_t decode(input logic [IW-1:0] w1,
                                        input logic [IW-1:0] w2,
                                        input logic          ext_en);
        ifd_dec_t   d;
        logic [3:0] nib;
        logic [3:0] sub;
        d   = '0;
        nib = w1[NIB_HI:NIB_LO];
        sub = w1[SUB_HI:SUB_LO];
        d.group    = GRP_NONE;
        d.tbl_mode = TBL_KEEP;
        if (nib == NIB_CTRL) begin // RULE4
            d.group = GRP_CTRL;
            if (sub[EXT_BIT]) begin // RULE1
                if (ext_en) begin
                    d.ext     = 1'b1;
                    d.ext_idx = sub[XI_W-1:0];
                    d.opcode  = OP_W'(sub);
                end else begin
                    d.group   = GRP_NONE;
                    d.blocked = 1'b1;
                end
            end else begin
                d.opcode = OP_W'(sub);
                if (sub == SUB_RET) begin // RULE9
                    d.is_ret = 1'b1;
                    d.shadow = w1[RET_S]; // RULE18
                end else if (sub == SUB_TBLRD || sub == SUB_TBLWR) begin
                    d.tbl_rd   = (sub == SUB_TBLRD);
                    d.tbl_wr   = (sub == SUB_TBLWR);
                    d.tbl_mode = ifd_tbl_t'(w1[MM_HI:0]); // RULE17
                end
            end
        end else if (nib >= NIB_BYTE_LO && nib <= NIB_BYTE_HI) begin
            d.group     = GRP_BYTE; // RULE5
            d.opcode    = w1[NIB_HI:OPC_LO]; // RULE3
            d.to_file   = w1[D_BIT]; // RULE6
            d.access    = w1[A_BIT];
            d.file_addr = FA_W'(w1[F_HI:0]);
        end else if (nib == NIB_MOVE) begin
            d.group     = GRP_BYTE;
            d.dword     = 1'b1; // RULE2
            d.opcode    = OP_W'(nib);
            d.to_file   = 1'b1;
            d.access    = 1'b1;
            d.file_addr = w1[FA_W-1:0];
            d.file_dst  = w2[FA_W-1:0]; // RULE19
        end else if (nib >= NIB_BIT_LO && nib <= NIB_BIT_HI) begin
            d.group     = GRP_BIT; // RULE7
            d.opcode    = OP_W'(nib);
            d.bit_pos   = w1[BIT_HI:BIT_LO];
            d.access    = w1[A_BIT];
            d.file_addr = FA_W'(w1[F_HI:0]);
            d.to_file   = 1'b1;
            d.test      = (nib >= NIB_TEST_LO);
            d.literal   = SKIP_DIST;
        end else if (nib == NIB_LIT) begin
            d.group   = GRP_LIT; // RULE8
            d.opcode  = OP_W'(w1[LSUB_HI:LSUB_LO]);
            d.literal = PC_W'(w1[F_HI:0]);
        end else if (nib == NIB_LPTR) begin
            d.group   = GRP_LIT;
            d.dword   = 1'b1;
            d.opcode  = OP_W'(nib);
            d.ptr_sel = w1[PTR_HI:PTR_LO];
            d.literal = PC_W'({w1[KH_HI:0], w2[K2_HI:0]}); // RULE19
        end else if (nib == NIB_GOTO || nib == NIB_CALL) begin
            d.group   = GRP_CTRL;
            d.dword   = 1'b1;
            d.jump    = 1'b1;
            d.opcode  = OP_W'(nib);
            d.is_call = (nib == NIB_CALL);
            d.shadow  = (nib == NIB_CALL) && w1[CALL_S]; // RULE18
            d.literal = {w2[W2_HI:0], w1[F_HI:0]}; // RULE10
        end else if (nib == NIB_BRA) begin
            d.group  = GRP_CTRL;
            d.opcode = OP_W'(nib);
            if (w1[BRA_CB]) begin
                d.test    = 1'b1;
                d.literal = PC_W'(signed'(w1[BCC_HI:0]));
            end else begin
                d.jump    = 1'b1;
                d.literal = PC_W'(signed'(w1[BRA_HI:0]));
            end
        end
        // A lone second word has the ones nibble and falls through to no-op
        return d; // RULE11
    endfunction

    assign fresh  = decode(pm_data_in, NOP_WORD, ctrl[CTRL_EXT]);
    assign joined = decode(ir, pm_data_in, ctrl[CTRL_EXT]);

    // Decisions use the instruction that is executing in the closing cycle
    always_comb begin
        next_pc    = pc;
        next_ir    = ir;
        next_state = state;
        next_dec   = dec_q;
        next_valid = valid;
        if (tick) begin
            next_valid = 1'b0;
            next_dec   = '0;
            next_dec.group    = GRP_NONE;
            next_dec.tbl_mode = TBL_KEEP;
            next_state = ST_FLUSH;
            if (state == ST_EXEC && dec_q.dword) begin
                next_dec   = joined; // RULE13
                next_valid = 1'b1;
                next_state = ST_WORD2;
                next_pc    = dec_q.jump ? joined.literal : pc + PC_STEP;
            end else if (state == ST_EXEC && valid && dec_q.is_ret) begin
                next_pc = ret_addr_in; // RULE12
            end else if (state == ST_EXEC && valid && dec_q.jump) begin
                next_pc = pc + dec_q.literal;
            end else if (state == ST_EXEC && valid && dec_q.test && cond_true_in) begin
                // Skipped first word leaves its second word to run as a no-op
                next_pc = pc + dec_q.literal; // RULE15
            end else if (!ctrl[CTRL_HOLD]) begin
                next_ir    = pm_data_in;
                next_dec   = fresh;
                next_valid = (fresh.group != GRP_NONE) && !fresh.dword;
                next_state = ST_EXEC;
                next_pc    = pc + PC_STEP;
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pc    <= '0;
            ir    <= NOP_WORD;
            state <= ST_FLUSH;
            valid <= 1'b0;
            dec_q <= '0;
        end else begin
            pc    <= next_pc;
            ir    <= next_ir;
            state <= next_state;
            valid <= next_valid;
            dec_q <= next_dec;
        end
    end

    // Return address of a call is the word after its second word
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ret_pc <= '0;
        end else if (tick && state == ST_EXEC && dec_q.dword && dec_q.is_call) begin
            ret_pc <= pc + PC_STEP;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl <= CTRL_RST;
        end else if (reg_wr_in && reg_addr_in == REG_CTRL) begin
            ctrl <= reg_wdata_in[1:0];
        end
    end

    // Sticky: a disabled extended opcode arriving with a clear still sets it
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            blocked <= 1'b0;
        end else if (tick && next_state == ST_EXEC && fresh.blocked) begin
            blocked <= 1'b1;
        end else if (reg_wr_in && reg_addr_in == REG_STATUS && reg_wdata_in[ST_BLOCKED]) begin
            blocked <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rdata_out <= '0;
        end else if (!reg_rd_in) begin
            reg_rdata_out <= '0;
        end else if (reg_addr_in == REG_CTRL) begin
            reg_rdata_out <= DW'(ctrl);
        end else if (reg_addr_in == REG_STATUS) begin
            reg_rdata_out <= {blocked, dec_q.dword, valid, 2'h0, state};
        end else if (reg_addr_in == REG_IR_LO) begin
            reg_rdata_out <= ir[DW-1:0];
        end else if (reg_addr_in == REG_IR_HI) begin
            reg_rdata_out <= ir[IW-1:DW];
        end else begin
            reg_rdata_out <= '0;
        end
    end

    assign pm_addr_out           = pc;
    assign cycle_end_out         = tick;
    assign exec_valid_out        = valid;
    assign group_out             = dec_q.group;
    assign opcode_out            = dec_q.opcode;
    assign file_addr_out         = dec_q.file_addr;
    assign file_dst_out          = dec_q.file_dst;
    assign wr_accum_out          = valid && dec_q.group == GRP_BYTE && !dec_q.to_file; // RULE6
    assign wr_file_out           = valid && dec_q.to_file;
    assign access_bank_out       = !dec_q.access; // RULE16
    assign use_bank_selector_out = dec_q.access; // RULE16
    assign bit_pos_out           = dec_q.bit_pos;
    assign literal_out           = dec_q.literal;
    assign ptr_sel_out           = dec_q.ptr_sel;
    assign shadow_save_out       = valid && dec_q.is_call && dec_q.shadow; // RULE18
    assign shadow_restore_out    = valid && dec_q.is_ret && dec_q.shadow;
    assign tbl_rd_out            = dec_q.tbl_rd;
    assign tbl_wr_out            = dec_q.tbl_wr;
    assign tbl_mode_out          = dec_q.tbl_mode;
    assign call_out              = valid && dec_q.is_call;
    assign ret_out               = valid && dec_q.is_ret;
    assign ret_pc_out            = ret_pc;
    assign ext_op_out            = dec_q.ext;
    assign ext_idx_out           = dec_q.ext_idx;
    assign dword_out             = dec_q.dword;
    assign test_out              = dec_q.test;
endmodule

// ===== ifd_decoder_checker.sv
// Port-level assertions for the instruction format decoder, bound into it
module ifd_decoder_checker
    import ifd_pkg::*;
(
    input wire logic                core_clk_in,
    input wire logic                rst_in,
    input wire logic                reg_rd_in,
    input wire logic [DW-1:0]       reg_rdata_out,
    input wire logic                cond_true_in,
    input wire logic [PH_W-1:0]     phase_out,
    input wire logic                cycle_end_out,
    input wire logic                exec_valid_out,
    input wire ifd_pkg::ifd_group_t group_out,
    input wire logic [PC_W-1:0]     literal_out,
    input wire logic                wr_accum_out,
    input wire logic                wr_file_out,
    input wire logic                access_bank_out,
    input wire logic                use_bank_selector_out,
    input wire logic                shadow_save_out,
    input wire logic                shadow_restore_out,
    input wire logic                call_out,
    input wire logic                ret_out,
    input wire logic                dword_out,
    input wire logic                test_out
);
    default clocking dc @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_word1;
        phase_out == 2'h0 && dword_out && !exec_valid_out;
    endsequence
    sequence s_word2;
        exec_valid_out && dword_out;
    endsequence
    // A forced idle cycle spans four oscillator periods
    sequence s_idle_cycle;
        !exec_valid_out [*4];
    endsequence

    a_phase_count: assert property (
        cycle_end_out |=> !cycle_end_out [*3] ##1 cycle_end_out)
        else $error("cycle end not every fourth clock");
    a_end_phase: assert property (cycle_end_out == (phase_out == 2'h3))
        else $error("cycle end pulse off the last phase");
    a_fields_stand: assert property (phase_out != 2'h0 |->
        $stable(group_out) && $stable(exec_valid_out) && $stable(literal_out))
        else $error("decoded fields changed inside a cycle");
    a_dest_single: assert property (!(wr_accum_out && wr_file_out))
        else $error("both destinations selected");
    a_bank_select: assert property (access_bank_out == !use_bank_selector_out)
        else $error("access bank and bank selector disagree");
    a_word_pair: assert property (s_word1 |-> ##4 s_word2)
        else $error("second word did not execute next cycle");
    a_ret_flush: assert property (ret_out && cycle_end_out |=> s_idle_cycle)
        else $error("no idle cycle after return");
    a_skip_flush: assert property (
        test_out && exec_valid_out && cond_true_in && cycle_end_out |=> s_idle_cycle)
        else $error("no idle cycle after taken test");
    a_shadow_gate: assert property (
        (shadow_save_out |-> call_out) and (shadow_restore_out |-> ret_out))
        else $error("shadow access without call or return");
    a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
        else $error("read data outside the read answer cycle");
endmodule

bind ifd_decoder ifd_decoder_checker ifd_decoder_checker_i (.core_clk_in, .rst_in, .reg_rd_in,
    .reg_rdata_out, .cond_true_in, .phase_out, .cycle_end_out, .exec_valid_out, .group_out,
    .literal_out, .wr_accum_out, .wr_file_out, .access_bank_out, .use_bank_selector_out,
    .shadow_save_out, .shadow_restore_out, .call_out, .ret_out, .dword_out, .test_out);

// ===== ifd_phase.sv
// Four-phase instruction cycle generator driven by the oscillator clock
module ifd_phase
    import ifd_pkg::*;
#(
    parameter int N = PHASES
) (
    input  wire logic            core_clk_in,
    input  wire logic            rst_in,
    output logic [PH_W-1:0]      phase_out,
    output logic                 tick_out
);
    localparam logic [PH_W-1:0] LAST = PH_W'(N - 1);
    localparam logic [PH_W-1:0] ONE  = PH_W'(1);

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            phase_out <= '0;
        end else if (phase_out == LAST) begin
            phase_out <= '0;
        end else begin
            phase_out <= phase_out + ONE;
        end
    end

    // Last phase closes the instruction cycle
    assign tick_out = (phase_out == LAST);
endmodule

// ===== ifd_pkg.sv
// Shared constants, field layout and types of the instruction format decoder
package ifd_pkg;
    localparam int PHASES  = 4;
    localparam int PH_W    = 2;
    localparam int PC_W    = 20;
    localparam int IW      = 16;
    localparam int DW      = 8;
    localparam int RA_W    = 3;
    localparam int FA_W    = 12;
    localparam int OP_W    = 6;
    localparam int BP_W    = 3;
    localparam int PS_W    = 2;
    localparam int XI_W    = 3;
    localparam int BASE_OPS = 75;
    localparam int EXT_OPS  = 8;

    // Word field positions
    localparam int NIB_HI   = 15;
    localparam int NIB_LO   = 12;
    localparam int OPC_LO   = 10;
    localparam int D_BIT    = 9;
    localparam int A_BIT    = 8;
    localparam int F_HI     = 7;
    localparam int BIT_HI   = 11;
    localparam int BIT_LO   = 9;
    localparam int SUB_HI   = 7;
    localparam int SUB_LO   = 4;
    localparam int EXT_BIT  = 3;
    localparam int RET_S    = 0;
    localparam int CALL_S   = 8;
    localparam int MM_HI    = 1;
    localparam int PTR_HI   = 5;
    localparam int PTR_LO   = 4;
    localparam int KH_HI    = 3;
    localparam int K2_HI    = 7;
    localparam int W2_HI    = 11;
    localparam int BRA_CB   = 11;
    localparam int BRA_HI   = 10;
    localparam int BCC_HI   = 7;
    localparam int LSUB_HI  = 11;
    localparam int LSUB_LO  = 8;

    // Class codes held in the top nibble, control sub-codes in bits 7:4
    localparam logic [3:0] NIB_CTRL    = 4'h0;
    localparam logic [3:0] NIB_BYTE_LO = 4'h1;
    localparam logic [3:0] NIB_BYTE_HI = 4'h4;
    localparam logic [3:0] NIB_MOVE    = 4'h5;
    localparam logic [3:0] NIB_BIT_LO  = 4'h6;
    localparam logic [3:0] NIB_TEST_LO = 4'h8;
    localparam logic [3:0] NIB_BIT_HI  = 4'h9;
    localparam logic [3:0] NIB_LIT     = 4'hA;
    localparam logic [3:0] NIB_LPTR    = 4'hB;
    localparam logic [3:0] NIB_GOTO    = 4'hC;
    localparam logic [3:0] NIB_CALL    = 4'hD;
    localparam logic [3:0] NIB_BRA     = 4'hE;
    localparam logic [3:0] NIB_SECOND  = 4'hF;
    localparam logic [3:0] SUB_RET     = 4'h1;
    localparam logic [3:0] SUB_TBLRD   = 4'h2;
    localparam logic [3:0] SUB_TBLWR   = 4'h3;

    localparam logic [PC_W-1:0] SKIP_DIST = 20'h00001;
    localparam logic [PC_W-1:0] PC_STEP   = 20'h00001;
    localparam logic [IW-1:0]   NOP_WORD  = 16'h0000;

    // Register map
    localparam logic [RA_W-1:0] REG_CTRL   = 3'h0;
    localparam logic [RA_W-1:0] REG_STATUS = 3'h1;
    localparam logic [RA_W-1:0] REG_IR_LO  = 3'h2;
    localparam logic [RA_W-1:0] REG_IR_HI  = 3'h3;
    localparam int CTRL_EXT   = 0;
    localparam int CTRL_HOLD  = 1;
    localparam int ST_BLOCKED = 7;
    localparam logic [1:0] CTRL_RST = 2'h0;

    typedef enum logic [4:0] {
        GRP_NONE = 5'b00001,
        GRP_BYTE = 5'b00010,
        GRP_BIT  = 5'b00100,
        GRP_LIT  = 5'b01000,
        GRP_CTRL = 5'b10000
    } ifd_group_t;

    typedef enum logic [2:0] {
        ST_EXEC  = 3'b001,
        ST_WORD2 = 3'b010,
        ST_FLUSH = 3'b100
    } ifd_state_t;

    typedef enum logic [1:0] {
        TBL_KEEP     = 2'h0,
        TBL_POST_INC = 2'h1,
        TBL_POST_DEC = 2'h2,
        TBL_PRE_INC  = 2'h3
    } ifd_tbl_t;

    typedef struct packed {
        ifd_group_t      group;
        logic [OP_W-1:0] opcode;
        logic [FA_W-1:0] file_addr;
        logic [FA_W-1:0] file_dst;
        logic            to_file;
        logic            access;
        logic [BP_W-1:0] bit_pos;
        logic [PC_W-1:0] literal;
        logic [PS_W-1:0] ptr_sel;
        logic            shadow;
        logic            tbl_rd;
        logic            tbl_wr;
        ifd_tbl_t        tbl_mode;
        logic            ext;
        logic [XI_W-1:0] ext_idx;
        logic            blocked;
        logic            test;
        logic            dword;
        logic            jump;
        logic            is_call;
        logic            is_ret;
    } ifd_dec_t;
endpackage

// ===== ifd_prog_mem.sv
// Program memory model answering the decoder's fetch address
module ifd_prog_mem
    import ifd_pkg::*;
#(
    parameter int DEPTH = 64
) (
    input  wire logic [PC_W-1:0] addr_in,
    output logic [IW-1:0]        data_out
);
    logic [IW-1:0] mem [DEPTH];
    // Beyond the loaded image the memory reads as no-operation words
    assign data_out = (addr_in < PC_W'(DEPTH)) ? mem[addr_in[5:0]] : NOP_WORD;
endmodule

// ===== test_instruction_format_decode.sv
// Self-checking bench for the instruction format decoder
module test_instruction_format_decode;
    timeunit 1ns;
    timeprecision 1ns;
    import ifd_pkg::*;

    logic            core_clk_in, rst_in, reg_wr_in, reg_rd_in, cond_true_in;
    logic [RA_W-1:0] reg_addr_in;
    logic [DW-1:0]   reg_wdata_in, reg_rdata_out, rd;
    logic [PC_W-1:0] pm_addr_out, ret_addr_in, literal_out, ret_pc_out;
    logic [IW-1:0]   pm_data_in;
    logic [PH_W-1:0] phase_out;
    logic [OP_W-1:0] opcode_out;
    logic [FA_W-1:0] file_addr_out, file_dst_out;
    logic [BP_W-1:0] bit_pos_out;
    logic [PS_W-1:0] ptr_sel_out;
    logic [XI_W-1:0] ext_idx_out;
    ifd_group_t      group_out;
    ifd_tbl_t        tbl_mode_out;
    logic            cycle_end_out, exec_valid_out, wr_accum_out, wr_file_out;
    logic            access_bank_out, use_bank_selector_out, shadow_save_out;
    logic            shadow_restore_out, tbl_rd_out, tbl_wr_out, call_out, ret_out;
    logic            ext_op_out, dword_out, test_out;
    int              num_errors, tests_run;

    ifd_decoder ifd_decoder_i (.core_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
        .reg_rd_in, .reg_rdata_out, .pm_addr_out, .pm_data_in, .cond_true_in, .ret_addr_in,
        .phase_out, .cycle_end_out, .exec_valid_out, .group_out, .opcode_out, .file_addr_out,
        .file_dst_out, .wr_accum_out, .wr_file_out, .access_bank_out, .use_bank_selector_out,
        .bit_pos_out, .literal_out, .ptr_sel_out, .shadow_save_out, .shadow_restore_out,
        .tbl_rd_out, .tbl_wr_out, .tbl_mode_out, .call_out, .ret_out, .ret_pc_out, .ext_op_out,
        .ext_idx_out, .dword_out, .test_out);
    ifd_prog_mem ifd_prog_mem_i (.addr_in(pm_addr_out), .data_out(pm_data_in));

    initial begin
        core_clk_in = 1'h0;
        forever #25 core_clk_in = ~core_clk_in;
    end

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] act, input logic [31:0] exp);
        tests_run++;
        if (act !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, act, exp);
        end
    endtask

    // Steps to the start of the next instruction cycle, then checks its valid flag
    task automatic cyc(input logic v);
        int n;
        n = 0;
        do begin
            @(posedge core_clk_in);
            #1;
            n++;
        end while (phase_out !== 2'h0 && n < 8);
        if (n >= 8) begin
            num_errors++;
            tally_and_finish();
        end
        chk(exec_valid_out, v);
    endtask

    task automatic reg_write(input logic [RA_W-1:0] a, input logic [DW-1:0] d);
        @(posedge core_clk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'h1;
        @(posedge core_clk_in);
        reg_wr_in    <= 1'h0;
    endtask

    task automatic reg_read(input logic [RA_W-1:0] a, output logic [DW-1:0] d);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'h1;
        @(posedge core_clk_in);
        reg_rd_in   <= 1'h0;
        #1;
        d = reg_rdata_out;
    endtask

    task automatic load(input int a, input logic [IW-1:0] w);
        ifd_prog_mem_i.mem[a] = w;
    endtask

    initial begin
        num_errors = 0;
        tests_run = 0;
        rst_in = 1'h1;
        reg_wr_in = 1'h0;
        reg_rd_in = 1'h0;
        reg_addr_in = 3'h0;
        reg_wdata_in = 8'h00;
        cond_true_in = 1'h1;
        ret_addr_in = 20'h00030;
        for (int i = 0; i < 64; i++) begin
            load(i, NOP_WORD);
        end
        load(8'h00, 16'h13AB);
        load(8'h01, 16'h1055);
        load(8'h02, 16'h6A3C);
        load(8'h03, 16'hA07E);
        load(8'h04, 16'hC010);
        load(8'h05, 16'hF000);
        load(8'h10, 16'h8000);
        load(8'h11, 16'hC0AA);
        load(8'h12, 16'hF123);
        load(8'h13, 16'hE002);
        load(8'h16, 16'hD120);
        load(8'h17, 16'hF000);
        load(8'h20, 16'h0011);
        for (int m = 0; m < 4; m++) begin
            load(8'h30 + m, 16'h0020 + IW'(m));
        end
        load(8'h34, 16'h0080);
        load(8'h35, 16'h8000);
        load(8'h36, 16'h1055);
        load(8'h37, 16'h5123);
        load(8'h38, 16'hF456);
        load(8'h39, 16'hB023);
        load(8'h3A, 16'hF045);
        repeat (4) @(posedge core_clk_in);
        rst_in <= 1'h0;
        cyc(1'h1);
        chk(group_out, GRP_BYTE);
        chk({wr_file_out, wr_accum_out, use_bank_selector_out}, 3'h5);
        chk(file_addr_out[7:0], 8'hAB);
        cyc(1'h1);
        chk({wr_file_out, wr_accum_out, access_bank_out}, 3'h3);
        chk(file_addr_out[7:0], 8'h55);
        cyc(1'h1);
        chk(group_out, GRP_BIT);
        chk({bit_pos_out, access_bank_out, file_addr_out[7:0]}, 12'hB3C);
        cyc(1'h1);
        chk(group_out, GRP_LIT);
        chk(literal_out[7:0], 8'h7E);
        cyc(1'h0);
        chk(dword_out, 1'h1);
        cyc(1'h1);
        chk(group_out, GRP_CTRL);
        cyc(1'h1);
        chk(test_out, 1'h1);
        cyc(1'h0);
        cyc(1'h0);
        chk(group_out, GRP_NONE);
        cyc(1'h1);
        chk(group_out, GRP_CTRL);
        cyc(1'h0);
        cyc(1'h0);
        cyc(1'h1);
        chk({call_out, shadow_save_out, ret_pc_out}, 22'h300018);
        cyc(1'h1);
        chk({ret_out, shadow_restore_out}, 2'h3);
        cyc(1'h0);
        for (int m = 0; m < 4; m++) begin
            cyc(1'h1);
            chk({tbl_rd_out, tbl_mode_out}, 3'h4 + m[2:0]);
        end
        cyc(1'h0);
        chk(group_out, GRP_NONE);
        @(posedge core_clk_in);
        cond_true_in <= 1'h0;
        cyc(1'h1);
        cyc(1'h1);
        cyc(1'h0);
        cyc(1'h1);
        chk({opcode_out, file_addr_out, file_dst_out}, 30'h5123456);
        cyc(1'h0);
        cyc(1'h1);
        chk({ptr_sel_out, literal_out}, 22'h200345);
        $display("test program flow done");
        reg_read(REG_STATUS, rd);
        chk(rd[ST_BLOCKED], 1'h1);
        reg_write(REG_STATUS, 8'h80);
        reg_read(REG_STATUS, rd);
        chk(rd[ST_BLOCKED], 1'h0);
        reg_read(3'h5, rd);
        chk(rd, 8'h00);
        reg_read(REG_CTRL, rd);
        chk(rd, 8'h00);
        reg_write(REG_CTRL, 8'h01);
        reg_read(REG_CTRL, rd);
        chk(rd, 8'h01);
        $display("test registers done");
        tally_and_finish();
    end
endmodule
